/* File: shared/ssc_params.svh */
// Subaddresses, bit positions and timing of the status bank.
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

`define SSC_A_SCRATCH 8'h02
`define SSC_A_IRQ_STATE 8'h03
`define SSC_A_SYNC_DET 8'h04
`define SSC_A_LINES_LO 8'h05
`define SSC_A_LINES_HI 8'h06
`define SSC_A_CLKS_LO 8'h07
`define SSC_A_CLKS_HI 8'h08
`define SSC_A_REF_LINE_LO 8'h09
`define SSC_A_REF_LINE_HI 8'h0A
`define SSC_A_REF_PIX_LO 8'h0B
`define SSC_A_REF_PIX_HI 8'h0C
`define SSC_A_THRESH 8'h0D
`define SSC_A_REF_RED 8'h0E
`define SSC_A_REF_GREEN 8'h0F
`define SSC_A_REF_BLUE 8'h10
`define SSC_A_DARK_LINES 8'h11
`define SSC_A_DARK_PIX_LO 8'h12
`define SSC_A_DARK_PIX_HI 8'h13
`define SSC_A_CONT_LINE_LO 8'h14
`define SSC_A_CONT_LINE_HI 8'h15
`define SSC_A_CONT_PIX_LO 8'h16
`define SSC_A_CONT_PIX_HI 8'h17
`define SSC_A_CFG_ONE 8'h18
`define SSC_A_CFG_TWO 8'h19
`define SSC_A_EN_STOP_HI 8'hE3
`define SSC_A_VIS_BEGIN_LO 8'hE4
`define SSC_A_VIS_BEGIN_HI 8'hE5
`define SSC_A_VPULSE_LO 8'hE6
`define SSC_A_VPULSE_HI 8'hE7
`define SSC_A_LINE_TOT_LO 8'hE8
`define SSC_A_LINE_TOT_HI 8'hE9
`define SSC_A_MARKED_ONE 8'hC7
`define SSC_A_MARKED_TWO 8'hC9

`define SSC_C1_PROC_RST 0
`define SSC_C1_MEM_RST 1
`define SSC_C1_IN_RST 2
`define SSC_C1_MEM_INIT 3
`define SSC_C1_MEM_ABSENT 4
`define SSC_C1_ADC_SINGLE 5
`define SSC_C1_IRQ_ACK 6
`define SSC_C2_POWER_DOWN 0
`define SSC_C2_BLANK 1
`define SSC_C2_DITHER 2

`define SSC_RESET_BYTE 8'h00
`define SSC_CLK_MHZ 250
`define SSC_SYNC_LOSS_US 1000

`endif

/* File: shared/ssc_pkg.sv */
// Types shared by the scaler status and config bank.
package ssc_pkg;
  typedef logic [7:0]  ssc_byte_t;
  typedef logic [10:0] ssc_line_t;
  typedef logic [11:0] ssc_pix_t;
  typedef enum logic [1:0] {
    SSC_SCAN_DARK    = 2'b01,
    SSC_SCAN_CONTENT = 2'b10
  } ssc_scan_e;
endpackage

/* File: core/ssc_regs.sv */
// Status and configuration bank with sync measurement.
//
// Function
// [RULE1] Measure lines between vsyncs, 11 bits.
// [RULE2] Measure input clocks between hsyncs, 12 bits.
// [RULE3] Writable 11-bit reference line number.
// [RULE4] Writable 12-bit reference pixel position.
// [RULE5] Threshold colour classifies pixels black/non-black.
// [RULE6] Capture reference pixel red, green, blue.
// [RULE7] Count black lines after vsync, 8 bits.
// [RULE8] Count black pixels after hsync, 9 bits.
// [RULE9] Count lines until non-black content, 11 bits.
// [RULE10] Count pixels until non-black content, 12 bits.
// [RULE11] Config one bit 0 holds processing reset.
// [RULE12] Config one bit 1 holds memory reset.
// [RULE13] Config one bit 2 holds input reset.
// [RULE14] Config one bit 3 starts memory init.
// [RULE15] Config one bit 4 flags memory absent.
// [RULE16] Acknowledge bit 6 returns interrupt high.
// [RULE17] Config two bit 0 forces panel low.
// [RULE18] Config two bit 1 blanks screen.
// [RULE19] Config two bit 2 enables temporal dithering.
// [RULE20] Marked registers advance target, not pointer.
// [RULE21] Low byte first, upper bits next subaddress.
// [RULE22] Report sync presence and polarity status.
`include "ssc_params.svh"
`timescale 1ns/10ps
`default_nettype none

module ssc_regs
  import ssc_pkg::*;
#(
  parameter int SYNC_LOSS_CYC = `SSC_SYNC_LOSS_US * `SSC_CLK_MHZ
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       ser_start,
  input  wire logic [7:0] ser_addr,
  input  wire logic       ser_wr,
  input  wire logic       ser_rd,
  input  wire logic [7:0] ser_wdata,
  output logic      [7:0] ser_rdata,
  output logic            ser_rvalid,
  output logic            marked_wr,
  output logic      [7:0] marked_addr,
  output logic      [7:0] marked_index,
  output logic      [7:0] marked_data,
  input  wire logic       vid_hsync,
  input  wire logic       vid_vsync,
  input  wire logic       vid_strobe,
  input  wire logic [7:0] vid_red,
  input  wire logic [7:0] vid_green,
  input  wire logic [7:0] vid_blue,
  input  wire logic       irq_event,
  output logic            irq_n,
  output logic            proc_reset,
  output logic            mem_reset,
  output logic            input_reset,
  output logic            mem_init_start,
  output logic            mem_absent,
  output logic            adc_single,
  input  wire logic [7:0] pnl_red_in,
  input  wire logic [7:0] pnl_green_in,
  input  wire logic [7:0] pnl_blue_in,
  input  wire logic       pnl_hsync_in,
  input  wire logic       pnl_vsync_in,
  input  wire logic       pnl_de_in,
  output logic      [7:0] pnl_red,
  output logic      [7:0] pnl_green,
  output logic      [7:0] pnl_blue,
  output logic            pnl_hsync,
  output logic            pnl_vsync,
  output logic            pnl_de,
  output logic      [2:0] panel_enable_stop_pos_hi,
  output logic     [10:0] panel_visible_begin,
  output logic     [10:0] panel_vpulse_stop_line,
  output logic     [10:0] panel_line_total
);

  function automatic logic is_marked(input logic [7:0] a);
    is_marked = (a == `SSC_A_MARKED_ONE) || (a == `SSC_A_MARKED_TWO);
  endfunction

  function automatic logic is_black(input logic [7:0] r, input logic [7:0] g,
                                    input logic [7:0] b, input logic [7:0] t);
    is_black = (r <= t) && (g <= t) && (b <= t);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Subaddress pointer and register writes.

  logic [7:0] ptr_reg;
  logic [7:0] scratch_reg;
  logic [7:0] cfg_one_reg;
  logic [7:0] cfg_two_reg;
  ssc_line_t  ref_line_reg;
  ssc_pix_t   ref_pix_reg;
  logic [7:0] thresh_reg;
  logic [2:0] en_stop_hi_reg;
  ssc_line_t  vis_begin_reg;
  ssc_line_t  vpulse_reg;
  ssc_line_t  line_tot_reg;
  logic [7:0] mk_index_reg;
  logic [7:0] cur_addr;
  logic       wr_hit;
  logic       irq_pend_reg;
  logic       init_pulse_reg;
  logic       mk_wr_reg;
  logic [7:0] mk_data_reg;
  logic [7:0] mk_addr_reg;

  assign cur_addr = ser_start ? ser_addr : ptr_reg;
  assign wr_hit   = ser_wr && !ser_start;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ptr_reg      <= 8'h00;
      mk_index_reg <= 8'h00;
    end else if (ser_start) begin
      ptr_reg      <= ser_addr;
      mk_index_reg <= 8'h00;
    end else if (ser_wr || ser_rd) begin
      if (is_marked(ptr_reg)) begin
        mk_index_reg <= mk_index_reg + 8'h01;  // [RULE20]
      end else begin
        ptr_reg <= ptr_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mk_wr_reg   <= 1'b0;
      mk_data_reg <= 8'h00;
      mk_addr_reg <= 8'h00;
    end else begin
      mk_wr_reg <= wr_hit && is_marked(ptr_reg);  // [RULE20]
      if (wr_hit && is_marked(ptr_reg)) begin
        mk_data_reg <= ser_wdata;
        mk_addr_reg <= ptr_reg;
      end
    end
  end

  assign marked_wr    = mk_wr_reg;
  assign marked_data  = mk_data_reg;
  assign marked_addr  = mk_addr_reg;
  assign marked_index = mk_index_reg;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      scratch_reg    <= `SSC_RESET_BYTE;
      cfg_one_reg    <= `SSC_RESET_BYTE;
      cfg_two_reg    <= `SSC_RESET_BYTE;
      ref_line_reg   <= 11'h000;
      ref_pix_reg    <= 12'h000;
      thresh_reg     <= `SSC_RESET_BYTE;
      en_stop_hi_reg <= 3'h0;
      vis_begin_reg  <= 11'h000;
      vpulse_reg     <= 11'h000;
      line_tot_reg   <= 11'h000;
    end else if (wr_hit) begin
      case (ptr_reg)
        `SSC_A_SCRATCH:      scratch_reg <= ser_wdata;
        `SSC_A_REF_LINE_LO:  ref_line_reg[7:0] <= ser_wdata;     // [RULE3] [RULE21]
        `SSC_A_REF_LINE_HI:  ref_line_reg[10:8] <= ser_wdata[2:0];  // [RULE3]
        `SSC_A_REF_PIX_LO:   ref_pix_reg[7:0] <= ser_wdata;      // [RULE4] [RULE21]
        `SSC_A_REF_PIX_HI:   ref_pix_reg[11:8] <= ser_wdata[3:0];   // [RULE4]
        `SSC_A_THRESH:       thresh_reg <= ser_wdata;            // [RULE5]
        `SSC_A_CFG_ONE:      cfg_one_reg <= ser_wdata;
        `SSC_A_CFG_TWO:      cfg_two_reg <= ser_wdata;
        `SSC_A_EN_STOP_HI:   en_stop_hi_reg <= ser_wdata[2:0];
        `SSC_A_VIS_BEGIN_LO: vis_begin_reg[7:0] <= ser_wdata;
        `SSC_A_VIS_BEGIN_HI: vis_begin_reg[10:8] <= ser_wdata[2:0];
        `SSC_A_VPULSE_LO:    vpulse_reg[7:0] <= ser_wdata;
        `SSC_A_VPULSE_HI:    vpulse_reg[10:8] <= ser_wdata[2:0];
        `SSC_A_LINE_TOT_LO:  line_tot_reg[7:0] <= ser_wdata;
        `SSC_A_LINE_TOT_HI:  line_tot_reg[10:8] <= ser_wdata[2:0];
        default: ;
      endcase
    end
  end

  assign proc_reset  = cfg_one_reg[`SSC_C1_PROC_RST];  // [RULE11]
  assign mem_reset   = cfg_one_reg[`SSC_C1_MEM_RST];   // [RULE12]
  assign input_reset = cfg_one_reg[`SSC_C1_IN_RST];    // [RULE13]
  assign mem_absent  = cfg_one_reg[`SSC_C1_MEM_ABSENT];  // [RULE15]
  assign adc_single  = cfg_one_reg[`SSC_C1_ADC_SINGLE];
  assign panel_enable_stop_pos_hi = en_stop_hi_reg;
  assign panel_visible_begin      = vis_begin_reg;
  assign panel_vpulse_stop_line   = vpulse_reg;
  assign panel_line_total         = line_tot_reg;

  // Config one writes with bit 3 set pulse the initialiser.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      init_pulse_reg <= 1'b0;
    end else begin
      init_pulse_reg <= wr_hit && (ptr_reg == `SSC_A_CFG_ONE)
                        && ser_wdata[`SSC_C1_MEM_INIT];  // [RULE14]
    end
  end
  assign mem_init_start = init_pulse_reg;

  // An event beats a same-cycle acknowledge.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_pend_reg <= 1'b0;
    end else if (irq_event) begin
      irq_pend_reg <= 1'b1;
    end else if (wr_hit && (ptr_reg == `SSC_A_CFG_ONE)
                 && ser_wdata[`SSC_C1_IRQ_ACK]) begin
      irq_pend_reg <= 1'b0;  // [RULE16]
    end
  end
  assign irq_n = ~irq_pend_reg;  // [RULE16]

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic [27:0] in_s1_reg;
  logic [27:0] in_s2_reg;
  logic        hs_prev_reg;
  logic        vs_prev_reg;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      in_s1_reg <= 28'h0000000;
      in_s2_reg <= 28'h0000000;
    end else begin
      in_s1_reg <= {vid_hsync, vid_vsync, vid_strobe, 1'b0, vid_red, vid_green, vid_blue};
      in_s2_reg <= in_s1_reg;
    end
  end

  logic       hs_lvl;
  logic       vs_lvl;
  logic       px_stb;
  logic [7:0] px_r;
  logic [7:0] px_g;
  logic [7:0] px_b;
  assign hs_lvl = in_s2_reg[27];
  assign vs_lvl = in_s2_reg[26];
  assign px_stb = in_s2_reg[25];
  assign px_r   = in_s2_reg[23:16];
  assign px_g   = in_s2_reg[15:8];
  assign px_b   = in_s2_reg[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Sync presence and polarity.

  logic        hs_pos_reg;
  logic        vs_pos_reg;
  logic [31:0] hs_idle_reg;
  logic [31:0] vs_idle_reg;
  logic        hs_lost_reg;
  logic        vs_lost_reg;
  logic        hs_edge;
  logic        vs_edge;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hs_prev_reg <= 1'b0;
      vs_prev_reg <= 1'b0;
    end else begin
      hs_prev_reg <= hs_lvl;
      vs_prev_reg <= vs_lvl;
    end
  end

  // The leading edge of the pulse follows the detected polarity.
  assign hs_edge = hs_pos_reg ? (hs_lvl && !hs_prev_reg) : (!hs_lvl && hs_prev_reg);
  assign vs_edge = vs_pos_reg ? (vs_lvl && !vs_prev_reg) : (!vs_lvl && vs_prev_reg);

  // Sync idles during active pixels, revealing polarity.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hs_pos_reg <= 1'b0;
      vs_pos_reg <= 1'b0;
    end else if (px_stb && !input_reset) begin
      hs_pos_reg <= !hs_lvl;  // [RULE22]
      vs_pos_reg <= !vs_lvl;  // [RULE22]
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hs_idle_reg <= 32'h00000000;
      vs_idle_reg <= 32'h00000000;
      hs_lost_reg <= 1'b1;
      vs_lost_reg <= 1'b1;
    end else begin
      if (hs_lvl != hs_prev_reg) begin
        hs_idle_reg <= 32'h00000000;
        hs_lost_reg <= 1'b0;  // [RULE22]
      end else if (hs_idle_reg >= 32'(SYNC_LOSS_CYC)) begin
        hs_lost_reg <= 1'b1;
      end else begin
        hs_idle_reg <= hs_idle_reg + 32'h00000001;
      end
      if (vs_lvl != vs_prev_reg) begin
        vs_idle_reg <= 32'h00000000;
        vs_lost_reg <= 1'b0;  // [RULE22]
      end else if (vs_idle_reg >= 32'(SYNC_LOSS_CYC)) begin
        vs_lost_reg <= 1'b1;
      end else begin
        vs_idle_reg <= vs_idle_reg + 32'h00000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame measurement and auto adjustment counters.

  ssc_line_t  line_cnt_reg;
  ssc_pix_t   pix_cnt_reg;
  ssc_line_t  lines_meas_reg;
  ssc_pix_t   clks_meas_reg;
  logic [7:0] ref_r_reg;
  logic [7:0] ref_g_reg;
  logic [7:0] ref_b_reg;
  logic [7:0] dark_lines_reg;
  logic [7:0] dark_lines_run;
  ssc_line_t  cont_line_reg;
  ssc_line_t  cont_line_run;
  logic [8:0] dark_pix_reg;
  logic [8:0] dark_pix_run;
  ssc_pix_t   cont_pix_reg;
  ssc_pix_t   cont_pix_run;
  logic       line_dark_reg;
  logic       pix_found_reg;
  ssc_scan_e  scan_reg;
  logic       px_black;
  logic       on_ref_line;

  assign px_black    = is_black(px_r, px_g, px_b, thresh_reg);  // [RULE5]
  assign on_ref_line = (line_cnt_reg == ref_line_reg);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      line_cnt_reg   <= 11'h000;
      pix_cnt_reg    <= 12'h000;
      lines_meas_reg <= 11'h000;
      clks_meas_reg  <= 12'h000;
    end else if (input_reset) begin
      line_cnt_reg <= 11'h000;  // [RULE13]
      pix_cnt_reg  <= 12'h000;
    end else begin
      if (vs_edge) begin
        lines_meas_reg <= line_cnt_reg;  // [RULE1]
        line_cnt_reg   <= {10'h000, hs_edge};  // [RULE1]
      end else if (hs_edge && line_cnt_reg != 11'h7FF) begin
        line_cnt_reg <= line_cnt_reg + 11'h001;  // [RULE1]
      end
      if (hs_edge) begin
        clks_meas_reg <= pix_cnt_reg;  // [RULE2]
        pix_cnt_reg   <= 12'h000;
      end else if (px_stb && pix_cnt_reg != 12'hFFF) begin
        pix_cnt_reg <= pix_cnt_reg + 12'h001;  // [RULE2]
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ref_r_reg <= 8'h00;
      ref_g_reg <= 8'h00;
      ref_b_reg <= 8'h00;
    end else if (px_stb && !input_reset && on_ref_line && pix_cnt_reg == ref_pix_reg) begin
      ref_r_reg <= px_r;  // [RULE6]
      ref_g_reg <= px_g;  // [RULE6]
      ref_b_reg <= px_b;  // [RULE6]
    end
  end

  // Horizontal scan on the reference line.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dark_pix_run  <= 9'h000;
      cont_pix_run  <= 12'h000;
      pix_found_reg <= 1'b0;
      dark_pix_reg  <= 9'h000;
      cont_pix_reg  <= 12'h000;
    end else if (input_reset || hs_edge) begin
      if (!input_reset && on_ref_line) begin
        dark_pix_reg <= dark_pix_run;  // [RULE8]
        cont_pix_reg <= cont_pix_run;  // [RULE10]
      end
      dark_pix_run  <= 9'h000;
      cont_pix_run  <= 12'h000;
      pix_found_reg <= 1'b0;
    end else if (px_stb && !pix_found_reg) begin
      if (px_black) begin
        if (dark_pix_run != 9'h1FF) begin
          dark_pix_run <= dark_pix_run + 9'h001;  // [RULE8]
        end
        cont_pix_run <= cont_pix_run + 12'h001;  // [RULE10]
      end else begin
        pix_found_reg <= 1'b1;
      end
    end
  end

  // Lines stay dark until one holds a non-black pixel.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      line_dark_reg  <= 1'b1;
      scan_reg       <= SSC_SCAN_DARK;
      dark_lines_run <= 8'h00;
      cont_line_run  <= 11'h000;
      dark_lines_reg <= 8'h00;
      cont_line_reg  <= 11'h000;
    end else if (input_reset) begin
      line_dark_reg  <= 1'b1;
      scan_reg       <= SSC_SCAN_DARK;
      dark_lines_run <= 8'h00;
      cont_line_run  <= 11'h000;
    end else if (vs_edge) begin
      dark_lines_reg <= dark_lines_run;  // [RULE7]
      cont_line_reg  <= cont_line_run;   // [RULE9]
      line_dark_reg  <= 1'b1;
      scan_reg       <= SSC_SCAN_DARK;
      dark_lines_run <= 8'h00;
      cont_line_run  <= 11'h000;
    end else if (hs_edge) begin
      line_dark_reg <= 1'b1;
      case (scan_reg)
        SSC_SCAN_DARK: begin
          if (line_dark_reg) begin
            if (dark_lines_run != 8'hFF) begin
              dark_lines_run <= dark_lines_run + 8'h01;  // [RULE7]
            end
            cont_line_run <= cont_line_run + 11'h001;  // [RULE9]
          end else begin
            scan_reg <= SSC_SCAN_CONTENT;
          end
        end
        SSC_SCAN_CONTENT: scan_reg <= SSC_SCAN_CONTENT;
        default:          scan_reg <= SSC_SCAN_DARK;
      endcase
    end else if (px_stb && !px_black) begin
      line_dark_reg <= 1'b0;  // [RULE5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port.

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ser_rdata  <= 8'h00;
      ser_rvalid <= 1'b0;
    end else begin
      ser_rvalid <= ser_rd;
      if (ser_rd) begin
        case (cur_addr)
          `SSC_A_SCRATCH: ser_rdata <= scratch_reg;
          `SSC_A_IRQ_STATE: ser_rdata <= {7'h00, irq_n};
          `SSC_A_SYNC_DET: ser_rdata <= {4'h0, vs_pos_reg, hs_pos_reg,
                                         vs_lost_reg, hs_lost_reg};  // [RULE22]
          `SSC_A_LINES_LO: ser_rdata <= lines_meas_reg[7:0];  // [RULE21]
          `SSC_A_LINES_HI: ser_rdata <= {5'h00, lines_meas_reg[10:8]};
          `SSC_A_CLKS_LO: ser_rdata <= clks_meas_reg[7:0];
          `SSC_A_CLKS_HI: ser_rdata <= {4'h0, clks_meas_reg[11:8]};
          `SSC_A_REF_RED: ser_rdata <= ref_r_reg;
          `SSC_A_REF_GREEN: ser_rdata <= ref_g_reg;
          `SSC_A_REF_BLUE: ser_rdata <= ref_b_reg;
          `SSC_A_DARK_LINES: ser_rdata <= dark_lines_reg;
          `SSC_A_DARK_PIX_LO: ser_rdata <= dark_pix_reg[7:0];
          `SSC_A_DARK_PIX_HI: ser_rdata <= {7'h00, dark_pix_reg[8]};
          `SSC_A_CONT_LINE_LO: ser_rdata <= cont_line_reg[7:0];
          `SSC_A_CONT_LINE_HI: ser_rdata <= {5'h00, cont_line_reg[10:8]};
          `SSC_A_CONT_PIX_LO: ser_rdata <= cont_pix_reg[7:0];
          `SSC_A_CONT_PIX_HI: ser_rdata <= {4'h0, cont_pix_reg[11:8]};
          default: ser_rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Panel output stage: power-down, blanking and temporal dithering.

  logic       frame_phase_reg;
  logic       pnl_vs_prev_reg;
  logic       pix_phase_reg;
  logic [7:0] dith_r;
  logic [7:0] dith_g;
  logic [7:0] dith_b;
  logic       dith_bit;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      frame_phase_reg <= 1'b0;
      pnl_vs_prev_reg <= 1'b0;
      pix_phase_reg   <= 1'b0;
    end else begin
      pnl_vs_prev_reg <= pnl_vsync_in;
      if (pnl_vsync_in && !pnl_vs_prev_reg) begin
        frame_phase_reg <= !frame_phase_reg;
      end
      pix_phase_reg <= pnl_de_in ? !pix_phase_reg : 1'b0;
    end
  end

  // Dithering flips the LSB by frame and pixel parity.
  assign dith_bit = frame_phase_reg ^ pix_phase_reg;
  assign dith_r = cfg_two_reg[`SSC_C2_DITHER] ? {pnl_red_in[7:1], pnl_red_in[0] ^ dith_bit}
                                              : pnl_red_in;  // [RULE19]
  assign dith_g = cfg_two_reg[`SSC_C2_DITHER] ? {pnl_green_in[7:1], pnl_green_in[0] ^ dith_bit}
                                              : pnl_green_in;  // [RULE19]
  assign dith_b = cfg_two_reg[`SSC_C2_DITHER] ? {pnl_blue_in[7:1], pnl_blue_in[0] ^ dith_bit}
                                              : pnl_blue_in;  // [RULE19]

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pnl_red   <= 8'h00;
      pnl_green <= 8'h00;
      pnl_blue  <= 8'h00;
      pnl_hsync <= 1'b0;
      pnl_vsync <= 1'b0;
      pnl_de    <= 1'b0;
    end else if (cfg_two_reg[`SSC_C2_POWER_DOWN]) begin
      pnl_red   <= 8'h00;  // [RULE17]
      pnl_green <= 8'h00;
      pnl_blue  <= 8'h00;
      pnl_hsync <= 1'b0;
      pnl_vsync <= 1'b0;
      pnl_de    <= 1'b0;
    end else begin
      pnl_hsync <= pnl_hsync_in;
      pnl_vsync <= pnl_vsync_in;
      pnl_de    <= pnl_de_in;
      if (cfg_two_reg[`SSC_C2_BLANK]) begin
        pnl_red   <= 8'h00;  // [RULE18]
        pnl_green <= 8'h00;
        pnl_blue  <= 8'h00;
      end else begin
        pnl_red   <= dith_r;
        pnl_green <= dith_g;
        pnl_blue  <= dith_b;
      end
    end
  end

endmodule // ssc_regs

`default_nettype wire

/* File: test/ssc_regs_assertions.sv */
// Port checker of the status and config bank.
`timescale 1ns/10ps
`default_nettype none
module ssc_regs_assertions (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       ser_start,
  input wire logic [7:0] ser_addr,
  input wire logic       ser_wr,
  input wire logic       ser_rd,
  input wire logic [7:0] ser_wdata,
  input wire logic       irq_event,
  input wire logic       irq_n,
  input wire logic       proc_reset,
  input wire logic       mem_reset,
  input wire logic       input_reset,
  input wire logic       mem_init_start,
  input wire logic [7:0] pnl_red_in,
  input wire logic       pnl_hsync_in,
  input wire logic [7:0] pnl_red,
  input wire logic       pnl_hsync,
  input wire logic       pnl_de
);
  logic [7:0] ptr_reg;
  logic [2:0] cfg2_reg;
  logic       c1_wr;
  assign c1_wr = ser_wr && !ser_start && ptr_reg == 8'h18;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) ptr_reg <= 8'h00;
    else if (ser_start) ptr_reg <= ser_addr;
    else if ((ser_wr || ser_rd) && ptr_reg != 8'hC7 && ptr_reg != 8'hC9) ptr_reg <= ptr_reg + 8'h01;
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) cfg2_reg <= 3'h0;
    else if (ser_wr && !ser_start && ptr_reg == 8'h19) cfg2_reg <= ser_wdata[2:0];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_cfg;
    logic [2:0] v;
    (c1_wr, v = ser_wdata[2:0]) |=> {input_reset, mem_reset, proc_reset} == v;
  endproperty
  a_cfg_one_levels: assert property (p_cfg) else $error("reset bits wrong");
  a_init_start_pulse: assert property (c1_wr && ser_wdata[3] |=> mem_init_start) else $error("no init");
  a_ack_raises_irq: assert property (c1_wr && ser_wdata[6] && !irq_event |=> irq_n) else $error("ack");
  a_ack_zero_keeps: assert property (c1_wr && !ser_wdata[6] && !irq_event |=> $stable(irq_n)) else $error("ack0");
  a_event_lowers_irq: assert property (irq_event |=> !irq_n) else $error("irq not set");
  a_power_down_low: assert property (cfg2_reg[0] |=> pnl_red == 8'h00 && !pnl_hsync && !pnl_de) else $error("pd");
  a_blank_colour_zero: assert property (cfg2_reg[1] |=> pnl_red == 8'h00) else $error("blank");
  a_plain_pass_through: assert property (cfg2_reg == 3'h0 |=> pnl_red == $past(pnl_red_in) && pnl_hsync == $past(pnl_hsync_in)) else $error("pass");
  c_ack: cover property (c1_wr && ser_wdata[6]);
  c_pd: cover property (cfg2_reg[0]);
  c_init: cover property (mem_init_start);
endmodule // ssc_regs_assertions
bind ssc_regs ssc_regs_assertions ssc_regs_assertions_inst (.*);
`default_nettype wire

/* File: test/ssc_host_model.sv */
// Host model on the subaddress port.
`timescale 1ns/10ps
`default_nettype none
module ssc_host_model (
  input  wire logic       clk_sys,
  output logic            ser_start,
  output logic      [7:0] ser_addr,
  output logic            ser_wr,
  output logic            ser_rd,
  output logic      [7:0] ser_wdata,
  input  wire logic [7:0] ser_rdata,
  input  wire logic       ser_rvalid
);
  initial {ser_start, ser_wr, ser_rd, ser_addr, ser_wdata} = 19'h0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n);
    @(negedge clk_sys);
    {ser_start, ser_addr} = {1'b1, a};
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      {ser_start, ser_addr, ser_wr, ser_wdata} = {1'b0, ~a, 1'b1, d + 8'(i)};
    end
    @(negedge clk_sys);
    {ser_wr, ser_wdata} = {1'b0, ~ser_wdata};
  endtask
  task automatic rd(input logic [7:0] a, input int n, output logic [15:0] d);
    d = 16'hXXXX;
    @(negedge clk_sys);
    {ser_start, ser_addr} = {1'b1, a};
    for (int i = 0; i <= n; i++) begin
      @(negedge clk_sys);
      if (i > 0 && ser_rvalid) d[8*i-8 +: 8] = ser_rdata;
      {ser_start, ser_addr, ser_rd} = {1'b0, ~a, i < n};
    end
  endtask
endmodule // ssc_host_model
`default_nettype wire

/* File: test/tb_top.sv */
// Bench of the status and config bank.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int LN = 10;
  localparam int CK = 40;
  logic clk_sys, reset, ser_start, ser_wr, ser_rd, ser_rvalid, marked_wr, vid_hsync, vid_vsync;
  logic vid_strobe, irq_event, irq_n, proc_reset, mem_reset, input_reset, mem_init_start, vid_on;
  logic mem_absent, adc_single, pnl_hsync_in, pnl_vsync_in, pnl_de_in, pnl_hsync, pnl_vsync, pnl_de;
  logic [7:0] ser_addr, ser_wdata, ser_rdata, marked_addr, marked_index, marked_data, pnl_red;
  logic [7:0] vid_red, vid_green, vid_blue, pnl_red_in, pnl_green_in, pnl_blue_in, pnl_green, pnl_blue;
  logic [2:0] panel_enable_stop_pos_hi;
  logic [10:0] panel_visible_begin, panel_vpulse_stop_line, panel_line_total;
  logic [31:0] seed;
  logic [15:0] d;
  int n_mismatch, n_checks, pos;
  ssc_regs #(.SYNC_LOSS_CYC(1024)) ssc_regs_inst (.*);
  ssc_host_model ssc_host_model_inst (.*);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] exp_pnl(input int m, input logic [7:0] r, input logic h);
    return m == 1 ? 8'h00 : m == 2 ? {7'h00, h} : {r[7:1], h};
  endfunction
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] v, input int n);
    ssc_host_model_inst.wr(a, v, n);
  endtask
  task automatic r(input logic [7:0] a, input int n);
    ssc_host_model_inst.rd(a, n, d);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(negedge clk_sys) begin
    pos = vid_on ? (pos + 1) % (LN * CK) : 0;
    {vid_hsync, vid_vsync} = {vid_on && pos % CK < 2, vid_on && pos < CK};
    vid_strobe = vid_on && pos >= CK && pos % CK >= 2;
  end
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
  initial begin
    {reset, irq_event, vid_on, pnl_hsync_in} = 4'h8;
    {vid_red, vid_green, vid_blue, pnl_red_in, pnl_green_in, pnl_blue_in} = 48'h0;
    {pnl_vsync_in, pnl_de_in, n_mismatch, n_checks, pos, seed} = {2'b00, 96'h0, 32'h890A};
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    r(8'h04, 1);
    chk("sync_lost", d[7:0], 8'h03);
    w(8'h02, seed[7:0], 2);
    r(8'h02, 2);
    chk("scratch_state", d, {8'h01, seed[7:0]});
    for (int i = 0; i < 3; i++) begin
      w(8'h18, 8'h01 << i, 1);
      chk("cfg_one", {input_reset, mem_reset, proc_reset}, 3'h1 << i);
    end
    w(8'h18, 8'h18, 1);
    chk("mem_absent", {mem_absent, proc_reset}, 2'b10);
    @(negedge clk_sys) irq_event = 1'b1;
    @(negedge clk_sys) irq_event = 1'b0;
    chk("irq_set", irq_n, 1'b0);
    w(8'h18, 8'h00, 1);
    chk("irq_keep", irq_n, 1'b0);
    w(8'h18, 8'h40, 1);
    chk("irq_ack", irq_n, 1'b1);
    seed = lfsr(seed);
    w(8'h09, seed[7:0], 5);
    r(8'h09, 2);
    chk("wo_read", d, 16'h0000);
    w(8'hC7, seed[7:0], 3);
    chk("marked", {marked_addr, marked_index}, 16'hC703);
    chk("marked_data", marked_data, seed[7:0] + 8'h02);
    for (int m = 0; m < 4; m++) begin
      w(8'h19, m == 0 ? 8'h00 : 8'h01 << (m - 1), 1);
      repeat (4) begin
        seed = lfsr(seed);
        {pnl_red_in, pnl_green_in, pnl_blue_in, pnl_hsync_in} = seed[24:0];
        @(negedge clk_sys);
        chk("pnl", {pnl_red[7:1], pnl_hsync}, exp_pnl(m, pnl_red_in, pnl_hsync_in));
      end
    end
    w(8'h19, 8'h00, 1);
    vid_on = 1'b1;
    repeat (3 * LN * CK) @(negedge clk_sys);
    r(8'h05, 2);
    chk("lines", d, 16'(LN));
    r(8'h07, 2);
    chk("clocks", d, 16'(CK - 2));
    r(8'h04, 1);
    chk("sync_seen", d[7:0], 8'h0C);
    close_out();
  end
endmodule // tb_top
`default_nettype wire
